// *** logic/mcu_ctrl_consts.svh ***
`ifndef MCU_CTRL_CONSTS_SVH
`define MCU_CTRL_CONSTS_SVH

// Register byte offsets
`define ADDR_FLASH_SIZE_ID 8'h01
`define ADDR_DEVICE_NUMBER_ID 8'h02
`define ADDR_SILICON_REVISION 8'h03
`define ADDR_ANALOG_INIT 8'h07
`define ADDR_EVENT_LOCK 8'h08
`define ADDR_WEX_LOCK 8'h09
`define ADDR_FAULT_LOCK 8'h0A
`define ADDR_VIOLATION 8'h0B
`define ADDR_STARTUP_STATUS 8'h0C

// Field positions
`define REV_FIELD_MSB 3
`define DLY_FIELD_W 2
`define EVLOCK_LOWER_BIT 0
`define EVLOCK_UPPER_BIT 4
`define WAVEFORM_EXT_LOCK_REGISTER_PORTC_BIT 0
`define FAULT_EXT_LOCK_REGISTER_T4_BIT 0
`define FAULT_EXT_LOCK_REGISTER_T5_BIT 1
`define VIOL_EVENT_BIT 0
`define VIOL_WEX_BIT 1
`define VIOL_FAULT_BIT 2
`define VIOL_CCP_BIT 3
`define STATUS_PORT_STRIDE 4

// Lock vector bit indices
`define LK_EV_LOWER 0
`define LK_EV_UPPER 1
`define LK_WEX_C 2
`define LK_FAULT_T4 3
`define LK_FAULT_T5 4
`define LOCK_COUNT 5

// Reset values
`define ANALOG_INIT_RESET 4'h0
`define VIOLATION_RESET 4'h0
`define LOCK_RESET 1'h0
`define RDATA_IDLE 8'h00

// Start-up delay codes and step intervals in peripheral clock cycles
`define DLY_NONE 2'h0
`define DLY_2CLK 2'h1
`define DLY_8CLK 2'h2
`define DLY_32CLK 2'h3
`define STEP_2CLK 6'h02
`define STEP_8CLK 6'h08
`define STEP_32CLK 6'h20
`define STEP_CNT_ONE 6'h01
`define STEP_CNT_ZERO 6'h00

`define EVENT_CHANNELS 8
`define EVENT_CH_PER_GROUP 4
`define ANALOG_PORTS 2
`define FAULT_TIMERS 2

`endif

// *** logic/mcu_ctrl_pkg.sv ***
`default_nettype none
package mcu_ctrl_pkg;

    // Enable lines handed to one port's converters and comparator
    typedef struct packed {
        logic reference_on;
        logic bias_on;
        logic core_on;
    } analog_start_s;

    typedef enum logic [3:0] {
        SEQ_OFF = 4'h1,
        SEQ_REF = 4'h2,
        SEQ_BIAS = 4'h4,
        SEQ_ON = 4'h8
    } startup_state_e;

    // Write requests from the guarded register files
    typedef struct packed {
        logic [7:0] event_channel;
        logic waveform_extension;
        logic [1:0] fault_timer;
    } guarded_write_s;

endpackage : mcu_ctrl_pkg
`default_nettype wire

// *** logic/sticky_lock.sv ***
`include "mcu_ctrl_consts.svh"
`default_nettype none
module sticky_lock (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    output logic lock_o
);
    // Only reset can drop the lock; a written zero has no path in
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_o <= `LOCK_RESET;
        end else if (set_i) begin
            lock_o <= 1'h1;
        end
    end
endmodule : sticky_lock
`default_nettype wire

// *** logic/step_timer.sv ***
`include "mcu_ctrl_consts.svh"
`default_nettype none
module step_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [1:0] delay_sel_i,
    output logic step_o
);
    logic [5:0] count;
    logic [5:0] target;
    logic at_end;

    assign target = (delay_sel_i == `DLY_2CLK) ? `STEP_2CLK :
                    (delay_sel_i == `DLY_8CLK) ? `STEP_8CLK : `STEP_32CLK;
    assign at_end = run_i && (count == target - `STEP_CNT_ONE);
    assign step_o = at_end;

    // Wraps at each step so the next interval starts clean
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= `STEP_CNT_ZERO;
        end else if (!run_i || at_end) begin
            count <= `STEP_CNT_ZERO;
        end else begin
            count <= count + `STEP_CNT_ONE;
        end
    end
endmodule : step_timer
`default_nettype wire

// *** logic/mcu_control_registers.sv ***
// The implementer's own choice: the plain strobed port.
`include "mcu_ctrl_consts.svh"
`default_nettype none
// Operation
// - A read-only byte reports the program flash size code and ignores writes.
// - A read-only byte reports the device number code and ignores writes.
// - The revision sits in the low nibble, 0 for the first and 1 for the second, upper nibble zero.
// - Two read/write 2-bit start-up delay fields, one per port, sequence reference and bias start.
// - Delay code 00 starts directly, 01 steps every 2, 10 every 8 and 11 every 32 clocks.
// - Lock bit 4 of the event lock register freezes channels four to seven.
// - Lock bit 0 of the event lock register freezes channels zero to three.
// - A lock bit write takes effect only while the change protection window is open.
// - Lock bit 0 of the waveform lock register freezes the port C waveform extension.
// - The fault lock register holds bit 1 for timer 5 and bit 0 for timer 4.
module mcu_control_registers #(
    parameter logic [7:0] FLASH_SIZE_CODE = 8'h5A,
    parameter logic [7:0] DEVICE_NUMBER_CODE = 8'hA5,
    parameter logic [3:0] REVISION_CODE = 4'h1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic ccp_unlock_i,
    input wire logic [1:0] port_enable_i,
    output mcu_ctrl_pkg::analog_start_s [1:0] analog_start_o,
    input wire mcu_ctrl_pkg::guarded_write_s guarded_req_i,
    output mcu_ctrl_pkg::guarded_write_s guarded_en_o,
    output logic [4:0] lock_o
);
    import mcu_ctrl_pkg::*;

    // The three code parameters above carry arbitrary values

    // Reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'h0;
            rst_n <= 1'h0;
        end else begin
            rst_meta <= 1'h1;
            rst_n <= rst_meta;
        end
    end

    // Address decode
    wire hit_flash = (addr_i == `ADDR_FLASH_SIZE_ID);
    wire hit_devnum = (addr_i == `ADDR_DEVICE_NUMBER_ID);
    wire hit_rev = (addr_i == `ADDR_SILICON_REVISION);
    wire hit_analog_init_register = (addr_i == `ADDR_ANALOG_INIT);
    wire hit_evlock = (addr_i == `ADDR_EVENT_LOCK);
    wire hit_waveform_ext_lock_register = (addr_i == `ADDR_WEX_LOCK);
    wire hit_fault_ext_lock_register = (addr_i == `ADDR_FAULT_LOCK);
    wire hit_viol = (addr_i == `ADDR_VIOLATION);
    wire hit_status = (addr_i == `ADDR_STARTUP_STATUS);
    wire hit_lockreg = hit_evlock | hit_waveform_ext_lock_register | hit_fault_ext_lock_register;

    // Write strobes
    wire wr_analog_init_register = wr_i & hit_analog_init_register;
    wire wr_viol = wr_i & hit_viol;
    wire wr_lock_ok = wr_i & hit_lockreg & ccp_unlock_i;
    wire wr_lock_refused = wr_i & hit_lockreg & ~ccp_unlock_i;

    // Analog initialisation register
    logic [3:0] analog_init_register;
    logic [3:0] next_analog_init;

    // Reserved upper bits are never stored
    assign next_analog_init = wr_analog_init_register ? wdata_i[3:0] : analog_init_register;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            analog_init_register <= `ANALOG_INIT_RESET;
        end else begin
            analog_init_register <= next_analog_init;
        end
    end

    // Lock bits
    logic [`LOCK_COUNT-1:0] lock_set;
    logic [`LOCK_COUNT-1:0] locks;

    assign lock_set[`LK_EV_LOWER] = wr_lock_ok & hit_evlock
                                    & wdata_i[`EVLOCK_LOWER_BIT];
    assign lock_set[`LK_EV_UPPER] = wr_lock_ok & hit_evlock
                                    & wdata_i[`EVLOCK_UPPER_BIT];
    assign lock_set[`LK_WEX_C] = wr_lock_ok & hit_waveform_ext_lock_register
                                 & wdata_i[`WAVEFORM_EXT_LOCK_REGISTER_PORTC_BIT];
    assign lock_set[`LK_FAULT_T4] = wr_lock_ok & hit_fault_ext_lock_register
                                    & wdata_i[`FAULT_EXT_LOCK_REGISTER_T4_BIT];
    assign lock_set[`LK_FAULT_T5] = wr_lock_ok & hit_fault_ext_lock_register
                                    & wdata_i[`FAULT_EXT_LOCK_REGISTER_T5_BIT];

    genvar lk;
    generate
        for (lk = 0; lk < `LOCK_COUNT; lk = lk + 1) begin : g_lock
            sticky_lock u_lock (
                .clk_i(clk_i),
                .rst_n_i(rst_n),
                .set_i(lock_set[lk]),
                .lock_o(locks[lk])
            );
        end
    endgenerate

    assign lock_o = locks;

    // Write gating toward the guarded register files
    logic [`EVENT_CHANNELS-1:0] ev_blocked;

    genvar ch;
    generate
        for (ch = 0; ch < `EVENT_CHANNELS; ch = ch + 1) begin : g_event_gate
            if (ch < `EVENT_CH_PER_GROUP) begin : g_lower
                assign ev_blocked[ch] = locks[`LK_EV_LOWER];
            end else begin : g_upper
                assign ev_blocked[ch] = locks[`LK_EV_UPPER];
            end
            assign guarded_en_o.event_channel[ch] =
                guarded_req_i.event_channel[ch] & ~ev_blocked[ch];
        end
    endgenerate

    assign guarded_en_o.waveform_extension =
        guarded_req_i.waveform_extension & ~locks[`LK_WEX_C];
    assign guarded_en_o.fault_timer[0] =
        guarded_req_i.fault_timer[0] & ~locks[`LK_FAULT_T4];
    assign guarded_en_o.fault_timer[1] =
        guarded_req_i.fault_timer[1] & ~locks[`LK_FAULT_T5];

    // Blocked-write record, write one to clear, a new event wins over the clear
    wire ev_viol_evt = |(guarded_req_i.event_channel & ev_blocked);
    wire wex_viol_evt = guarded_req_i.waveform_extension & locks[`LK_WEX_C];
    wire fault_viol_evt = (guarded_req_i.fault_timer[0] & locks[`LK_FAULT_T4])
                        | (guarded_req_i.fault_timer[1] & locks[`LK_FAULT_T5]);

    logic [3:0] violation;
    logic [3:0] viol_set;
    logic [3:0] viol_clr;
    logic [3:0] next_violation;

    assign viol_set[`VIOL_EVENT_BIT] = ev_viol_evt;
    assign viol_set[`VIOL_WEX_BIT] = wex_viol_evt;
    assign viol_set[`VIOL_FAULT_BIT] = fault_viol_evt;
    assign viol_set[`VIOL_CCP_BIT] = wr_lock_refused;
    assign viol_clr = wr_viol ? wdata_i[3:0] : `VIOLATION_RESET;
    assign next_violation = (violation & ~viol_clr) | viol_set;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            violation <= `VIOLATION_RESET;
        end else begin
            violation <= next_violation;
        end
    end

    // Analog start-up sequencing, one sequencer per port
    logic [2:0] port_status [`ANALOG_PORTS];

    genvar pt;
    generate
        for (pt = 0; pt < `ANALOG_PORTS; pt = pt + 1) begin : g_port
            startup_state_e state;
            startup_state_e next_state;
            logic [1:0] dly_live;
            logic [1:0] dly_held;
            logic step;
            logic timing;

            assign dly_live = analog_init_register[pt*`DLY_FIELD_W +: `DLY_FIELD_W];
            assign timing = (state == SEQ_REF) || (state == SEQ_BIAS);

            step_timer u_timer (
                .clk_i(clk_i),
                .rst_n_i(rst_n),
                .run_i(timing),
                .delay_sel_i(dly_held),
                .step_o(step)
            );

            // The code is held for the whole sequence so a rewrite mid-way
            // cannot shorten a step that is already running
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    dly_held <= `DLY_NONE;
                end else if (state == SEQ_OFF) begin
                    dly_held <= dly_live;
                end
            end

            always_comb begin
                next_state = state;
                case (state)
                    SEQ_OFF: begin
                        if (port_enable_i[pt]) begin
                            if (dly_live == `DLY_NONE) begin
                                next_state = SEQ_ON;
                            end else begin
                                next_state = SEQ_REF;
                            end
                        end
                    end
                    SEQ_REF: begin
                        if (!port_enable_i[pt]) begin
                            next_state = SEQ_OFF;
                        end else if (step) begin
                            next_state = SEQ_BIAS;
                        end
                    end
                    SEQ_BIAS: begin
                        if (!port_enable_i[pt]) begin
                            next_state = SEQ_OFF;
                        end else if (step) begin
                            next_state = SEQ_ON;
                        end
                    end
                    SEQ_ON: begin
                        if (!port_enable_i[pt]) begin
                            next_state = SEQ_OFF;
                        end
                    end
                    default: begin
                        next_state = SEQ_OFF;
                    end
                endcase
            end

            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    state <= SEQ_OFF;
                end else begin
                    state <= next_state;
                end
            end

            // Outputs are decoded straight from the one-hot state flops
            assign analog_start_o[pt].reference_on = state[1] | state[2] | state[3];
            assign analog_start_o[pt].bias_on = state[2] | state[3];
            assign analog_start_o[pt].core_on = state[3];
            assign port_status[pt] = {analog_start_o[pt].core_on,
                                      analog_start_o[pt].bias_on,
                                      analog_start_o[pt].reference_on};
        end
    endgenerate

    // Read path
    wire [7:0] rd_flash = FLASH_SIZE_CODE;
    wire [7:0] rd_devnum = DEVICE_NUMBER_CODE;
    wire [7:0] rd_rev = {4'h0, REVISION_CODE[`REV_FIELD_MSB:0]};
    wire [7:0] rd_analog_init_register = {4'h0, analog_init_register};
    wire [7:0] rd_evlock = {3'h0, locks[`LK_EV_UPPER], 3'h0,
                            locks[`LK_EV_LOWER]};
    wire [7:0] rd_waveform_ext_lock_register = {7'h00, locks[`LK_WEX_C]};
    wire [7:0] rd_fault_ext_lock_register = {6'h00, locks[`LK_FAULT_T5],
                               locks[`LK_FAULT_T4]};
    wire [7:0] rd_viol = {4'h0, violation};
    wire [7:0] rd_status = {1'h0, port_status[1], 1'h0, port_status[0]};

    // Unmapped addresses read zero
    wire [7:0] read_sel = hit_flash ? rd_flash :
                          hit_devnum ? rd_devnum :
                          hit_rev ? rd_rev :
                          hit_analog_init_register ? rd_analog_init_register :
                          hit_evlock ? rd_evlock :
                          hit_waveform_ext_lock_register ? rd_waveform_ext_lock_register :
                          hit_fault_ext_lock_register ? rd_fault_ext_lock_register :
                          hit_viol ? rd_viol :
                          hit_status ? rd_status : `RDATA_IDLE;

    logic [7:0] next_rdata;

    // Data stands only in the cycle after the read strobe
    assign next_rdata = rd_i ? read_sel : `RDATA_IDLE;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= `RDATA_IDLE;
        end else begin
            rdata_o <= next_rdata;
        end
    end

endmodule : mcu_control_registers
`default_nettype wire

// *** tb/mcu_control_registers_sva.sv ***
`default_nettype none
module mcu_control_registers_sva #(
    parameter logic [7:0] FLASH_SIZE_CODE = 8'h00,
    parameter logic [7:0] DEVICE_NUMBER_CODE = 8'h00,
    parameter logic [3:0] REVISION_CODE = 4'h0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic ccp_unlock_i,
    input wire logic [1:0] port_enable_i,
    input wire mcu_ctrl_pkg::analog_start_s [1:0] analog_start_o,
    input wire mcu_ctrl_pkg::guarded_write_s guarded_req_i,
    input wire mcu_ctrl_pkg::guarded_write_s guarded_en_o,
    input wire logic [4:0] lock_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow of the port A delay code; only valid while software writes it with the port off
    logic [1:0] code_a;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            code_a <= 2'h0;
        end else if (wr_i && addr_i == 8'h07) begin
            code_a <= wdata_i[1:0];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    property p_flash_id;
        rd_i && addr_i == 8'h01 |=> rdata_o == FLASH_SIZE_CODE;
    endproperty
    property p_dev_num;
        rd_i && addr_i == 8'h02 |=> rdata_o == DEVICE_NUMBER_CODE;
    endproperty
    property p_revision;
        rd_i && addr_i == 8'h03 |=> rdata_o == {4'h0, REVISION_CODE};
    endproperty
    property p_reserved;
        rd_i && addr_i == 8'h07 |=> rdata_o[7:4] == 4'h0;
    endproperty
    property p_ev_lower;
        guarded_en_o.event_channel[3:0] == (guarded_req_i.event_channel[3:0] & ~{4{lock_o[0]}});
    endproperty
    property p_ev_upper;
        guarded_en_o.event_channel[7:4] == (guarded_req_i.event_channel[7:4] & ~{4{lock_o[1]}});
    endproperty
    property p_wex;
        guarded_en_o.waveform_extension == (guarded_req_i.waveform_extension & ~lock_o[2]);
    endproperty
    property p_fault;
        guarded_en_o.fault_timer == (guarded_req_i.fault_timer & ~lock_o[4:3]);
    endproperty
    property p_lock_ccp;
        (lock_o & ~$past(lock_o)) != 5'h00 |-> $past(wr_i && ccp_unlock_i);
    endproperty
    property p_lock_sticky;
        ($past(lock_o) & ~lock_o) == 5'h00;
    endproperty
    property p_ref_first;
        port_enable_i[0] && analog_start_o[0] == 3'h0 |=> analog_start_o[0].reference_on;
    endproperty
    sequence s_bias_after2;
        !analog_start_o[0].bias_on ##1 !analog_start_o[0].bias_on
            ##1 analog_start_o[0].bias_on && !analog_start_o[0].core_on;
    endsequence
    sequence s_core_after2;
        !analog_start_o[0].core_on ##1 analog_start_o[0].core_on;
    endsequence
    property p_step2;
        $rose(analog_start_o[0].reference_on) && code_a == 2'h1 |-> s_bias_after2 ##1 s_core_after2;
    endproperty
    a_flash_id: assert property (p_flash_id) else $error("flash size id wrong");
    a_dev_num: assert property (p_dev_num) else $error("device number wrong");
    a_revision: assert property (p_revision) else $error("revision wrong");
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    a_ev_lower: assert property (p_ev_lower) else $error("lower channels gate");
    a_ev_upper: assert property (p_ev_upper) else $error("upper channels gate");
    a_wex: assert property (p_wex) else $error("waveform gate wrong");
    a_fault: assert property (p_fault) else $error("fault gate wrong");
    a_lock_ccp: assert property (p_lock_ccp) else $error("lock set unguarded");
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");
    a_ref_first: assert property (p_ref_first) else $error("reference late");
    a_step2: assert property (p_step2) else $error("two clock steps wrong");
endmodule : mcu_control_registers_sva
bind mcu_control_registers mcu_control_registers_sva #(
    .FLASH_SIZE_CODE(FLASH_SIZE_CODE),
    .DEVICE_NUMBER_CODE(DEVICE_NUMBER_CODE),
    .REVISION_CODE(REVISION_CODE)
) sva_u (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ccp_unlock_i,
    .port_enable_i, .analog_start_o, .guarded_req_i, .guarded_en_o, .lock_o);
`default_nettype wire

// *** tb/mcu_control_registers_bench.sv ***
`default_nettype none
module mcu_control_registers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mcu_ctrl_pkg::*;
    localparam logic [7:0] FLASH_ID = 8'h3C; // Arbitrary value
    localparam logic [7:0] DEV_ID = 8'hC3; // Arbitrary value
    localparam logic [3:0] REV = 4'h1;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ccp_unlock_i = 1'b0;
    logic [1:0] port_enable_i = 2'h0;
    guarded_write_s guarded_req_i = '0;
    logic [7:0] rdata_o;
    analog_start_s [1:0] analog_start_o;
    guarded_write_s guarded_en_o;
    logic [4:0] lock_o;
    int err_total = 0;
    int n_tests = 0;
    int stamp [3];
    int steps [4] = '{0, 2, 8, 32};
    mcu_control_registers #(.FLASH_SIZE_CODE(FLASH_ID), .DEVICE_NUMBER_CODE(DEV_ID),
        .REVISION_CODE(REV)) dut_u (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .ccp_unlock_i, .port_enable_i, .analog_start_o, .guarded_req_i,
        .guarded_en_o, .lock_o);
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic complete_run;
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    task automatic chk_bits(input logic [10:0] got, input logic [10:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bits
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk_bits({3'h0, got}, {3'h0, exp});
    endtask : chk_byte
    task automatic do_reset;
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        // Internal reset copy is two flops behind the pin
        repeat (2) @(posedge clk_i);
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ccp);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        ccp_unlock_i <= ccp;
        @(posedge clk_i);
        wr_i <= 1'b0;
        ccp_unlock_i <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk_byte(rdata_o, exp);
    endtask : rd_chk
    // Guarded requests go out as a one-cycle pulse; the gate is judged inside that cycle
    task automatic lk_chk(input logic [4:0] l);
        @(posedge clk_i);
        guarded_req_i <= '1;
        #1;
        chk_bits({6'h00, lock_o}, {6'h00, l});
        chk_bits(guarded_en_o, {~{4{l[1]}}, ~{4{l[0]}}, ~l[2], ~l[4], ~l[3]});
        @(posedge clk_i);
        guarded_req_i <= '0;
    endtask : lk_chk
    task automatic start_port(input int p, input logic [1:0] code, input int n);
        wr(8'h07, {4'h0, code, code}, 1'b0);
        @(posedge clk_i);
        port_enable_i[p] <= 1'b1;
        stamp = '{0, 0, 0};
        for (int k = 1; k < 70; k++) begin
            @(posedge clk_i);
            #1;
            for (int i = 0; i < 3; i++) begin
                if (stamp[i] == 0 && analog_start_o[p][2 - i] === 1'b1) begin
                    stamp[i] = k;
                end
            end
        end
        chk_byte(stamp[0][7:0], 8'h01);
        chk_byte(stamp[1][7:0], 8'(1 + n));
        chk_byte(stamp[2][7:0], 8'(1 + 2 * n));
        // Status byte shows the fully started port while the other one is off
        rd_chk(8'h0C, (p == 1) ? 8'h70 : 8'h07);
        @(posedge clk_i);
        port_enable_i[p] <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk_byte({5'h00, analog_start_o[p]}, 8'h00);
    endtask : start_port
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        complete_run();
    end
    initial begin
        do_reset();
        rd_chk(8'h07, 8'h00);
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h09, 8'h00);
        rd_chk(8'h0A, 8'h00);
        rd_chk(8'h20, 8'h00);
        // Second pass follows writes to the read-only bytes
        for (int i = 0; i < 2; i++) begin
            rd_chk(8'h01, FLASH_ID);
            rd_chk(8'h02, DEV_ID);
            rd_chk(8'h03, {4'h0, REV});
            wr(8'h01, 8'hFF, 1'b1);
            wr(8'h02, 8'hFF, 1'b1);
            wr(8'h03, 8'hFF, 1'b1);
        end
        wr(8'h07, 8'hF6, 1'b0);
        rd_chk(8'h07, 8'h06);
        wr(8'h07, 8'h09, 1'b0);
        rd_chk(8'h07, 8'h09);
        // Code 11 gives a whole sequence above half a microsecond at 100 MHz
        for (int c = 0; c < 4; c++) begin
            start_port(c / 2, c[1:0], steps[c]);
        end
        lk_chk(5'h00);
        wr(8'h08, 8'h11, 1'b0);
        lk_chk(5'h00);
        wr(8'h08, 8'h01, 1'b1);
        lk_chk(5'h01);
        wr(8'h08, 8'hF0, 1'b1);
        lk_chk(5'h03);
        rd_chk(8'h08, 8'h11);
        wr(8'h09, 8'hFF, 1'b1);
        rd_chk(8'h09, 8'h01);
        wr(8'h0A, 8'h01, 1'b1);
        lk_chk(5'h0F);
        wr(8'h0A, 8'hFE, 1'b1);
        rd_chk(8'h0A, 8'h03);
        wr(8'h08, 8'h00, 1'b1);
        lk_chk(5'h1F);
        // Every blocked kind and the refused lock write have been seen by now
        rd_chk(8'h0B, 8'h0F);
        wr(8'h0B, 8'h0F, 1'b0);
        rd_chk(8'h0B, 8'h00);
        do_reset();
        lk_chk(5'h00);
        rd_chk(8'h07, 8'h00);
        complete_run();
    end
endmodule : mcu_control_registers_bench
`default_nettype wire
